// ### hw/ssdp_top.sv
`timescale 1ns/1ps
module ssdp_top
  import ssdp_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       RESET_N_IN,
  input  wire logic [7:0] S_AXI_AWADDR_IN,
  input  wire logic       S_AXI_AWVALID_IN,
  output logic            S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0] S_AXI_WSTRB_IN,
  input  wire logic       S_AXI_WVALID_IN,
  output logic            S_AXI_WREADY_OUT,
  output logic [1:0]      S_AXI_BRESP_OUT,
  output logic            S_AXI_BVALID_OUT,
  input  wire logic       S_AXI_BREADY_IN,
  input  wire logic [7:0] S_AXI_ARADDR_IN,
  input  wire logic       S_AXI_ARVALID_IN,
  output logic            S_AXI_ARREADY_OUT,
  output logic [31:0]     S_AXI_RDATA_OUT,
  output logic [1:0]      S_AXI_RRESP_OUT,
  output logic            S_AXI_RVALID_OUT,
  input  wire logic       S_AXI_RREADY_IN,
  input  wire logic       SCK_IN,
  output logic            SCK_OUT,
  output logic            SCK_OE_OUT,
  input  wire logic       MOSI_IN,
  output logic            MOSI_OUT,
  output logic            MOSI_OE_OUT,
  input  wire logic       MISO_IN,
  output logic            MISO_OUT,
  output logic            MISO_OE_OUT,
  input  wire logic       SS_N_IN,
  output logic            IRQ_OUT
);
  typedef enum logic {ST_IDLE, ST_RUN} ssdp_mst_e;

  ssdp_ctrl_s ctrl_reg;
  ssdp_stat_s stat_view;
  ssdp_pins_s pins_raw;
  ssdp_pins_s pins_s;
  ssdp_mst_e  mst_reg;
  logic       rx_full_reg;
  logic       ovr_reg;
  logic       mode_fault_flag_reg;
  logic       txe_reg;
  logic       error_irq_enable_reg;
  logic       mode_fault_enable_reg;
  logic [1:0] baud_reg;
  logic [7:0] tx_buf_reg;
  logic [7:0] rx_buf_reg;
  logic [7:0] sh_reg;
  logic       samp_reg;
  logic [4:0] cnt_reg;
  logic       sck_out_reg;
  logic       sck_prev_reg;
  logic       ss_prev_reg;
  logic       loaded_reg;
  logic       arm_rx_reg;
  logic       arm_ovr_reg;
  logic       arm_mode_fault_flag_reg;
  logic       irq_reg;
  logic       aw_held_reg;
  logic       w_held_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic       wstrb_reg;
  logic       tick;
  logic       is_master;
  logic       is_slave;
  logic       slave_sel;
  logic       edge_ev;
  logic       lead;
  logic       in_bit;
  logic       shift_in;
  logic       sample_ev;
  logic       shift_ev;
  logic       byte_done;
  logic [7:0] rx_word;
  logic       mst_load;
  logic       slv_load;
  logic       slv_busy;
  logic       ss_rise;
  logic       mode_fault_flag_set;
  logic       wr_go;
  logic       ar_fire;
  logic       ctrl_wr;
  logic       stat_wr;
  logic       data_wr;
  logic       stat_rd;
  logic       data_rd;
  logic       irq_cond;
  logic       drive_m;

  // ********************************
  // Pin synchronisers
  // ********************************
  assign pins_raw = '{sck: SCK_IN, mosi: MOSI_IN, miso: MISO_IN, ss_n: SS_N_IN};

  ssdp_sync #(.W(4)) u_sync (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .d_in       (pins_raw),
    .q_out      (pins_s)
  );

  // ********************************
  // Mode decode
  // ********************************
  assign is_master = ctrl_reg.unit_enable && ctrl_reg.master_select;
  assign is_slave  = ctrl_reg.unit_enable && !ctrl_reg.master_select;
  assign slave_sel = is_slave && !pins_s.ss_n;

  ssdp_baud u_baud (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .run_in     (mst_reg == ST_RUN),
    .sel_in     (baud_reg),
    .tick_out   (tick)
  );

  // ********************************
  // Shift engine, shared by both roles
  // ********************************
  // Slave sees edges of the synchronised clock, so the master clock
  // must stay well below a quarter of the base clock
  assign edge_ev = (mst_reg == ST_RUN) ? tick
                 : (slave_sel && (pins_s.sck != sck_prev_reg));
  assign lead      = !cnt_reg[0];
  assign in_bit    = is_master ? pins_s.miso : pins_s.mosi;
  assign sample_ev = edge_ev && (lead ^ ctrl_reg.clk_phase);
  // Phase 1 skips the first shift so the data line holds across the first sampling edge
  assign shift_ev  = edge_ev && (ctrl_reg.clk_phase ? (lead && (cnt_reg != 5'h00))
                                                    : !lead);
  assign shift_in  = (ctrl_reg.clk_phase && cnt_reg == LAST_EDGE) ? in_bit : samp_reg;
  assign byte_done = edge_ev && (cnt_reg == LAST_EDGE);
  assign rx_word   = {sh_reg[6:0], shift_in};
  assign mst_load  = is_master && (mst_reg == ST_IDLE) && !txe_reg && !mode_fault_flag_reg;
  assign slv_load  = slave_sel && (cnt_reg == 5'h00) && !loaded_reg && !txe_reg && !edge_ev;
  assign slv_busy  = (cnt_reg != 5'h00) || loaded_reg;
  assign ss_rise   = !ss_prev_reg && pins_s.ss_n;

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      sck_prev_reg <= 1'b1;
      ss_prev_reg  <= 1'b1;
    end else begin
      sck_prev_reg <= pins_s.sck;
      ss_prev_reg  <= pins_s.ss_n;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      mst_reg <= ST_IDLE;
    end else begin
      unique case (mst_reg)
        ST_IDLE: if (mst_load) mst_reg <= ST_RUN;
        ST_RUN:  if (byte_done || !is_master || mode_fault_flag_reg) mst_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      cnt_reg <= 5'h00;
    end else if (mst_load || (!slave_sel && mst_reg != ST_RUN) || byte_done) begin
      cnt_reg <= 5'h00;
    end else if (edge_ev) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      sh_reg   <= 8'h00;
      samp_reg <= 1'b0;
    end else begin
      if (mst_load || slv_load) begin
        sh_reg <= tx_buf_reg;
      end else if (shift_ev) begin
        sh_reg <= rx_word;
      end
      if (sample_ev) begin
        samp_reg <= in_bit;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      loaded_reg <= 1'b0;
    end else if (slv_load) begin
      loaded_reg <= 1'b1;
    end else if (!slave_sel || byte_done) begin
      loaded_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      sck_out_reg <= 1'b0;
    end else if (mst_reg == ST_RUN && tick) begin
      sck_out_reg <= !sck_out_reg;
    end else if (mst_reg == ST_IDLE) begin
      sck_out_reg <= ctrl_reg.clk_polarity;
    end
  end

  // ********************************
  // Receive path and flags
  // ********************************
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      rx_buf_reg <= 8'h00;
    end else if (byte_done && !rx_full_reg) begin
      rx_buf_reg <= rx_word;
    end
  end

  // A new event beats a clear arriving in the same cycle, except that a clearing data read drops receiver-full even as a byte completes
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      rx_full_reg <= 1'b0;
      arm_rx_reg  <= 1'b0;
    end else begin
      if (byte_done && !rx_full_reg) begin
        rx_full_reg <= 1'b1;
      end else if (data_rd && arm_rx_reg) begin
        rx_full_reg <= 1'b0;
      end
      if (stat_rd && rx_full_reg) begin
        arm_rx_reg <= 1'b1;
      end else if (data_rd) begin
        arm_rx_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      ovr_reg     <= 1'b0;
      arm_ovr_reg <= 1'b0;
    end else begin
      if (byte_done && rx_full_reg) begin
        ovr_reg <= 1'b1;
      end else if (data_rd && arm_ovr_reg) begin
        ovr_reg <= 1'b0;
      end
      if (stat_rd && ovr_reg) begin
        arm_ovr_reg <= 1'b1;
      end else if (data_rd) begin
        arm_ovr_reg <= 1'b0;
      end
    end
  end

  // Master ignores the select pin unless fault detection is on
  assign mode_fault_flag_set = mode_fault_enable_reg && ((is_master && !pins_s.ss_n)
                                || (is_slave && ss_rise && slv_busy));

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      mode_fault_flag_reg     <= 1'b0;
      arm_mode_fault_flag_reg <= 1'b0;
    end else begin
      if (mode_fault_flag_set) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (ctrl_wr && arm_mode_fault_flag_reg) begin
        mode_fault_flag_reg <= 1'b0;
      end
      if (stat_rd && mode_fault_flag_reg) begin
        arm_mode_fault_flag_reg <= 1'b1;
      end else if (ctrl_wr) begin
        arm_mode_fault_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      txe_reg <= 1'b1;
    end else if (mst_load || slv_load) begin
      txe_reg <= 1'b1;
    end else if (data_wr) begin
      txe_reg <= 1'b0;
    end
  end

  // ********************************
  // Register bus
  // ********************************
  assign S_AXI_AWREADY_OUT = !aw_held_reg && !S_AXI_BVALID_OUT;
  assign S_AXI_WREADY_OUT  = !w_held_reg && !S_AXI_BVALID_OUT;
  assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
  assign wr_go   = aw_held_reg && w_held_reg;
  assign ar_fire = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign ctrl_wr = wr_go && wstrb_reg && (awaddr_reg == ADDR_CTRL);
  assign stat_wr = wr_go && wstrb_reg && (awaddr_reg == ADDR_STAT);
  assign data_wr = wr_go && wstrb_reg && (awaddr_reg == ADDR_DATA);
  assign stat_rd = ar_fire && (S_AXI_ARADDR_IN == ADDR_STAT);
  assign data_rd = ar_fire && (S_AXI_ARADDR_IN == ADDR_DATA);

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 8'h00;
      wstrb_reg   <= 1'b0;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= S_AXI_AWADDR_IN;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA_IN[7:0];
        wstrb_reg  <= S_AXI_WSTRB_IN[0];
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT  <= (awaddr_reg == ADDR_CTRL || awaddr_reg == ADDR_STAT ||
                           awaddr_reg == ADDR_DATA) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      ctrl_reg   <= CTRL_RESET;
      error_irq_enable_reg  <= STAT_RESET[6];
      mode_fault_enable_reg <= STAT_RESET[2];
      baud_reg   <= STAT_RESET[1:0];
      tx_buf_reg <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= ssdp_ctrl_s'(wdata_reg);
      end
      if (stat_wr) begin
        error_irq_enable_reg  <= wdata_reg[6];
        mode_fault_enable_reg <= wdata_reg[2];
        baud_reg   <= wdata_reg[1:0];
      end
      if (data_wr) begin
        tx_buf_reg <= wdata_reg;
      end
    end
  end

  assign stat_view = '{rx_full_flag: rx_full_reg, error_irq_enable: error_irq_enable_reg,
                       receive_overrun_flag: ovr_reg, mode_fault_flag: mode_fault_flag_reg,
                       tx_empty_flag: txe_reg, mode_fault_enable: mode_fault_enable_reg,
                       baud_select_high: baud_reg[1], baud_select_low: baud_reg[0]};

  // Data reads return the receive side only; the transmit byte is unreadable
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= 32'h0000_0000;
      S_AXI_RRESP_OUT  <= RESP_OKAY;
    end else if (ar_fire) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RRESP_OUT  <= RESP_OKAY;
      unique case (S_AXI_ARADDR_IN)
        ADDR_CTRL: S_AXI_RDATA_OUT <= {24'h000000, ctrl_reg};
        ADDR_STAT: S_AXI_RDATA_OUT <= {24'h000000, stat_view};
        ADDR_DATA: S_AXI_RDATA_OUT <= {24'h000000, rx_buf_reg};
        default: begin
          S_AXI_RDATA_OUT <= 32'h0000_0000;
          S_AXI_RRESP_OUT <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // ********************************
  // Interrupt and pins
  // ********************************
  assign irq_cond = (rx_full_reg && ctrl_reg.rx_irq_enable)
                 || (txe_reg && ctrl_reg.tx_empty_irq_enable)
                 || (error_irq_enable_reg && (ovr_reg || mode_fault_flag_reg));

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_cond;
    end
  end

  assign IRQ_OUT = irq_reg;

  // Wired-OR mode only ever pulls low; the pull-up lives outside
  assign drive_m     = is_master && !mode_fault_flag_reg;
  assign SCK_OUT     = sck_out_reg;
  assign MOSI_OUT    = sh_reg[7];
  assign MISO_OUT    = sh_reg[7];
  assign SCK_OE_OUT  = drive_m && (!ctrl_reg.wired_or || !sck_out_reg);
  assign MOSI_OE_OUT = drive_m && (!ctrl_reg.wired_or || !sh_reg[7]);
  assign MISO_OE_OUT = slave_sel && (!ctrl_reg.wired_or || !sh_reg[7]);

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_overrun_event;
    byte_done && rx_full_reg;
  endsequence
  sequence s_ovr_clear_step;
    data_rd && arm_ovr_reg;
  endsequence

  property p_ovr_set;
    s_overrun_event |=> ovr_reg;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("Overrun not flagged");
  property p_ovr_keep;
    s_overrun_event |=> (rx_buf_reg == $past(rx_buf_reg)) && rx_full_reg;
  endproperty
  a_ovr_keep: assert property (p_ovr_keep)
    else $error("Receive byte overwritten on overrun");
  property p_ovr_clear;
    $fell(ovr_reg) |-> $past(data_rd && arm_ovr_reg);
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("Overrun cleared outside read sequence");
  property p_ovr_clear_done;
    (s_ovr_clear_step ##0 !(byte_done && rx_full_reg)) |=> !ovr_reg;
  endproperty
  a_ovr_clear_done: assert property (p_ovr_clear_done)
    else $error("Overrun survived read sequence");
  property p_mode_fault_flag_slave;
    (is_slave && mode_fault_enable_reg && ss_rise && slv_busy) |=> mode_fault_flag_reg;
  endproperty
  a_mode_fault_flag_slave: assert property (p_mode_fault_flag_slave)
    else $error("Slave mode fault missed");
  property p_mode_fault_flag_master;
    (is_master && mode_fault_enable_reg && !pins_s.ss_n) |=> mode_fault_flag_reg [*2];
  endproperty
  a_mode_fault_flag_master: assert property (p_mode_fault_flag_master)
    else $error("Master mode fault missed");
  property p_mode_fault_flag_clear;
    $fell(mode_fault_flag_reg) |-> $past(ctrl_wr && arm_mode_fault_flag_reg);
  endproperty
  a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear)
    else $error("Mode fault cleared outside sequence");
  property p_mode_fault_flag_gate;
    $rose(mode_fault_flag_reg) |-> $past(mode_fault_enable_reg);
  endproperty
  a_mode_fault_flag_gate: assert property (p_mode_fault_flag_gate)
    else $error("Mode fault set while disabled");
  property p_txe;
    (mst_load || slv_load) |=> txe_reg ##0 (sh_reg == $past(tx_buf_reg));
  endproperty
  a_txe: assert property (p_txe)
    else $error("Transmit-empty not set on load");
  property p_txe_clr;
    (data_wr && !mst_load && !slv_load) |=> !txe_reg;
  endproperty
  a_txe_clr: assert property (p_txe_clr)
    else $error("Transmit-empty not cleared by write");
  property p_rx_full;
    (byte_done && !rx_full_reg) |=> rx_full_reg && (rx_buf_reg == $past(rx_word));
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("Received byte not captured");
  property p_slave_quiet;
    (is_slave && pins_s.ss_n) |-> !MISO_OE_OUT && !edge_ev;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("Deselected slave active");
  property p_irq;
    1'b1 |=> (IRQ_OUT == $past(irq_cond));
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt output wrong");
endmodule : ssdp_top

// ### shared/ssdp_pkg.sv
// Function
// - Set overrun flag when a byte completes while the previous byte is unread.
// - On overrun keep the old received byte and drop the new one.
// - Overrun clears by status read with flag set, then data read.
// - Slave with fault enable flags mode fault if select rises mid-transfer.
// - Master with fault enable flags mode fault whenever select is low.
// - Mode fault clears by status read with flag set, then control write.
// - Transmit-empty sets when a byte moves to the shifter; may interrupt.
// - Data write clears transmit-empty; reset sets it.
// - Mode fault sets only with enable on; clearing enable keeps the flag.
// - Master with fault enable off ignores the select pin entirely.
// - Slave always uses select; fault enable only gates the fault flag.
// - Baud field picks divisor 2, 8, 32 or 128.
// - Serial clock equals base clock over twice the divisor.
// - Baud field ignored as slave; reset clears it.
// - Data address writes transmit register, reads separate receive register.
// - Receiver-full sets on each received byte; clears by status then data read.
// - Error interrupt enable gates mode fault and overrun interrupts.
// - Slave needs select low; select high floats output and ignores clocks.
package ssdp_pkg;
  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] IDX_CTRL   = 8'h10;
  localparam logic [7:0] IDX_STAT   = 8'h11;
  localparam logic [7:0] IDX_DATA   = 8'h12;
  localparam logic [7:0] ADDR_CTRL  = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_STAT  = {IDX_STAT[5:0], 2'b00};
  localparam logic [7:0] ADDR_DATA  = {IDX_DATA[5:0], 2'b00};
  localparam logic [7:0] CTRL_RESET = 8'h28;
  localparam logic [7:0] STAT_RESET = 8'h08;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ********************************
  // Timing
  // ********************************
  localparam logic [7:0] BAUD_DIV_00 = 8'h02;
  localparam logic [7:0] BAUD_DIV_01 = 8'h08;
  localparam logic [7:0] BAUD_DIV_10 = 8'h20;
  localparam logic [7:0] BAUD_DIV_11 = 8'h80;
  localparam logic [4:0] LAST_EDGE   = 5'h0F;
  // ********************************
  // Carriers
  // ********************************
  typedef struct packed {
    logic rx_irq_enable;
    logic spare;
    logic master_select;
    logic clk_polarity;
    logic clk_phase;
    logic wired_or;
    logic unit_enable;
    logic tx_empty_irq_enable;
  } ssdp_ctrl_s;
  typedef struct packed {
    logic rx_full_flag;
    logic error_irq_enable;
    logic receive_overrun_flag;
    logic mode_fault_flag;
    logic tx_empty_flag;
    logic mode_fault_enable;
    logic baud_select_high;
    logic baud_select_low;
  } ssdp_stat_s;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } ssdp_pins_s;
endpackage : ssdp_pkg

// ### hw/ssdp_sync.sv
`timescale 1ns/1ps
module ssdp_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // Pins are idle high, so reset to ones avoids false edges
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_reg <= '1;
      q_out    <= '1;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : ssdp_sync

// ### hw/ssdp_baud.sv
`timescale 1ns/1ps
module ssdp_baud
  import ssdp_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       run_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);
  logic [7:0] div;
  logic [7:0] cnt_reg;
  logic [7:0] since_reg;

  always_comb begin
    unique case (sel_in)
      2'b00: div = BAUD_DIV_00;
      2'b01: div = BAUD_DIV_01;
      2'b10: div = BAUD_DIV_10;
      2'b11: div = BAUD_DIV_11;
    endcase
  end

  // One tick per half serial period: rate is base over twice the divisor
  assign tick_out = run_in && (cnt_reg == div - 8'h01);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !run_in || tick_out) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // ********************************
  // Checks
  // ********************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !run_in || tick_out) begin
      since_reg <= 8'h00;
    end else begin
      since_reg <= since_reg + 8'h01;
    end
  end

  property p_half_period;
    @(posedge clk_in) disable iff (!reset_n_in)
      (run_in && $stable(sel_in) && tick_out) |->
        (since_reg == (BAUD_DIV_00 << {sel_in, 1'b0}) - 8'h01);
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("Serial clock half period does not match divisor");
endmodule : ssdp_baud

// ### sim/ssdp_remote.sv
`timescale 1ns/1ps
module ssdp_remote #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  output logic [7:0]      got_out
);
  logic [7:0] tx_reg = REPLY;
  logic [7:0] seq_reg = REPLY;
  int         n_bits = 0;
  initial miso_out = 1'b0;
  initial got_out = 8'h00;
  always @(posedge sck_in) begin
    miso_out <= tx_reg[7];
    tx_reg   <= {tx_reg[6:0], 1'b0};
  end
  // Each frame answers a new byte; line inverts once released
  always @(negedge sck_in) begin
    got_out <= {got_out[6:0], mosi_in};
    n_bits = n_bits + 1;
    if (n_bits == 8) begin
      n_bits = 0;
      seq_reg = seq_reg + 8'h01;
      tx_reg <= seq_reg;
      miso_out <= ~miso_out;
    end
  end
endmodule : ssdp_remote

// ### sim/ssdp_top_tb.sv
`timescale 1ns/1ps
module ssdp_top_tb;
  import ssdp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ss_n = 1'b1, xsck = 1'b0, miso_oe;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, got;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, sck, sck_oe, mosi, mosi_oe, miso, irq;
  wire sck_w = (sck_oe === 1'b1) ? sck : xsck;
  wire mosi_w = (mosi_oe === 1'b1) ? mosi : 1'b1;
  int bad_count = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  ssdp_top DUT (.CLK_IN(clk), .RESET_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .SCK_IN(sck_w), .SCK_OUT(sck), .SCK_OE_OUT(sck_oe),
    .MOSI_IN(mosi_w), .MOSI_OUT(mosi), .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso),
    .MISO_OUT(), .MISO_OE_OUT(miso_oe), .SS_N_IN(ss_n), .IRQ_OUT(irq));
  ssdp_remote remote (.sck_in(sck_w), .mosi_in(mosi_w), .miso_out(miso), .got_out(got));
  // ********************************
  // Bus tasks
  // ********************************
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("BAD reg %h expected %h seen %h", a, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic axi(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] qo, output logic [1:0] ro);
    logic ta, tw, tr, dn;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      dn = w ? bvalid : rvalid;
      qo = rdata;
      ro = w ? bresp : rresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (dn) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end while (dn !== 1'b1);
  endtask : axi
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] qw;
    logic [1:0]  rw;
    axi(1'b1, a, d, qw, rw);
    chk(a, {30'h0, RESP_OKAY}, {30'h0, rw});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    axi(1'b0, a, 8'h00, q, r);
    chk(a, {24'h0, e}, q);
  endtask : rd
  task automatic poll(input logic [7:0] m);
    int i;
    i = 0;
    do begin
      axi(1'b0, ADDR_STAT, 8'h00, q, r);
      i++;
    end while ((q[7:0] & m) == 8'h00 && i < 300);
    chk(ADDR_STAT, {24'h0, m}, {24'h0, q[7:0] & m});
  endtask : poll
  task automatic summarize();
    $display("Checks made %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, 8'h28);
    rd(ADDR_STAT, 8'h08);
    axi(1'b0, 8'h4C, 8'h00, q, r);
    chk(8'h4C, {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(ADDR_STAT, 8'h01);
    wr(ADDR_CTRL, 8'h2A);
    chk(8'h40, 32'h0, {31'h0, irq});
    wr(ADDR_DATA, 8'hA5);
    poll(8'h80);
    rd(ADDR_STAT, 8'h89);
    rd(ADDR_DATA, 8'h3C);
    chk(ADDR_DATA, 32'hA5, {24'h0, got});
    rd(ADDR_STAT, 8'h09);
    wr(ADDR_DATA, 8'h11);
    poll(8'h80);
    wr(ADDR_DATA, 8'h22);
    poll(8'h20);
    rd(ADDR_STAT, 8'hA9);
    rd(ADDR_DATA, 8'h3D);
    rd(ADDR_STAT, 8'h09);
    wr(ADDR_STAT, 8'h05);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ADDR_STAT, 8'h1D);
    chk(8'h40, 32'h0, {31'h0, irq});
    wr(ADDR_STAT, 8'h01);
    rd(ADDR_STAT, 8'h19);
    wr(ADDR_CTRL, 8'h2A);
    rd(ADDR_STAT, 8'h09);
    ss_n <= 1'b1;
    wr(ADDR_CTRL, 8'h2B);
    repeat (3) @(negedge clk);
    chk(8'h40, 32'h1, {31'h0, irq});
    wr(ADDR_CTRL, 8'h0A);
    wr(ADDR_STAT, 8'h45);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk(8'h40, 32'h1, {31'h0, miso_oe});
    xsck <= 1'b1;
    repeat (4) @(posedge clk);
    xsck <= 1'b0;
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'h40, 32'h0, {31'h0, miso_oe});
    rd(ADDR_STAT, 8'h5D);
    chk(8'h40, 32'h1, {31'h0, irq});
    summarize();
  end
endmodule : ssdp_top_tb
